/* File: logic/tprf_top.sv */
// Operation
// R1 - format bits 00 serial, 01 parallel, 10 staggered; 11 reserved
// R2 - data strobes are driven together with every training read burst
// R3 - serial: addressed byte on every lane, bit 7 first, bit 0 last
// R4 - serial format works for reads of all four pages
// R5 - parallel: lane i carries bit 7-i, same value in every UI
// R6 - four lanes in parallel return bits 7 down to 4 only
// R7 - sixteen lanes in parallel repeat the byte on both bytes
// R8 - controller reads pages 1 to 3 only in serial format
// R9 - staggered: lane i sends location (n+i) mod 4 of page 0
// R10 - eight and sixteen lanes repeat the staggered rotation per nibble
// R11 - back-to-back reads stream with no idle UI between bursts
// R12 - mode command sets enable bit and page field
// R13 - page 0 read and write, pages 1 to 3 read-only
// R14 - page 0 holds its defaults from power-up until written
// R15 - page 0 changes only by a controller training write
// R16 - training writes to pages 1 to 3 are ignored
// R17 - defaults 0x55, 0x33, 0x0F, 0x00 for locations 0 to 3
// R18 - bank select bits choose the location within the page
// R19 - write data on address bits 7:0, bit 7 to bit 7
// R20 - controller never programs reserved format code 11
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tprf_top
(
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // apb slave
  input  wire logic [7:0]           paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // command link from the controller
  input  wire logic                 lnk_ck,
  input  wire logic                 cmd_sel_n,
  input  wire logic [1:0]           cmd_code,
  input  wire logic [12:0]          cmd_addr,
  input  wire logic                 bank_select_high,
  input  wire logic                 bank_select_low,
  // read-only page contents
  input  wire logic [95:0]          ro_page_data,
  // data return
  output logic      [tprf_pkg::LANES-1:0] dq_o,
  output logic                      dq_oe,
  output logic                      dqs_o,
  output logic                      dqs_oe
);
  import tprf_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic                   ck_s1;
    logic                   ck_s2;
    logic                   ck_prev;
    logic [PIN_W-1:0]       pin_s1;
    logic [PIN_W-1:0]       pin_s2;
    logic                   mr_en;
    logic [1:0]             mr_page;
    logic [1:0]             mr_fmt;
    logic [1:0]             lane_cfg;
    logic                   ign_flag;
    tprf_burst_t            bstate;
    logic [2:0]             ui;
    logic [LANES-1:0][7:0]  cur_word;
    logic [1:0]             cur_fmt;
    logic                   pend;
    logic [LANES-1:0][7:0]  pend_word;
    logic [1:0]             pend_fmt;
    logic [LANES-1:0]       dq;
    logic                   dqs;
    logic                   oe;
    logic [31:0]            rdata;
    logic                   err;
  } tprf_top_state_t;

  tprf_top_state_t        s;
  tprf_top_state_t        n;
  tprf_store_if           st ();

  logic                   link_rise;
  logic                   link_edge;
  logic                   c_sel_n;
  logic [1:0]             c_code;
  logic [12:0]            c_addr;
  logic [1:0]             c_bank;
  logic                   cmd_take;
  logic                   mrs_take;
  logic                   rd_take;
  logic                   wr_take;
  logic [4:0]             lanes_on;
  logic [LANES-1:0][7:0]  new_word;
  logic                   setup_ph;
  logic                   access_ph;

  // ****************************************************************
  // link decode
  // ****************************************************************
  // pins are sampled with the same two-stage delay as the clock, so they line up with its edge
  assign link_rise = s.ck_s2 && !s.ck_prev;
  assign link_edge = s.ck_s2 != s.ck_prev;
  assign c_sel_n   = s.pin_s2[17];
  assign c_code    = s.pin_s2[16:15];
  assign c_addr    = s.pin_s2[14:2];
  assign c_bank    = s.pin_s2[1:0];                                                          // [R18]
  assign cmd_take  = link_rise && !c_sel_n;
  assign mrs_take  = cmd_take && c_code == CMD_MRS;
  // with training disabled, array traffic is not ours and is left alone
  assign rd_take   = cmd_take && c_code == CMD_RD && s.mr_en;
  assign wr_take   = cmd_take && c_code == CMD_WR && s.mr_en;
  assign lanes_on  = (s.lane_cfg == WID_X4) ? 5'h04 : (s.lane_cfg == WID_X8) ? 5'h08 : 5'h10;

  assign st.wr_en   = wr_take;
  assign st.wr_page = s.mr_page;
  assign st.wr_loc  = c_bank;
  assign st.wr_data = c_addr[7:0];                                                           // [R19]
  assign st.rd_page = s.mr_page;
  assign st.rd_loc  = c_bank;
  assign st.ro_data = ro_page_data;

  tprf_store i_tprf_store (
    .pclk    (pclk),
    .presetn (presetn),
    .st      (st.store)
  );

  // ****************************************************************
  // per-lane burst words, bit 7 goes out first
  // ****************************************************************
  for (genvar gi = 0; gi < LANES; gi++)
  begin : g_lane
    localparam logic [1:0] NIB  = 2'(gi % 4);
    localparam int         PBIT = 7 - (gi % 8);
    logic [1:0] sloc;
    assign sloc = c_bank + NIB;                                                              // [R9] [R10]
    // reserved format 11 simply falls through to serial
    assign new_word[gi] = (5'(gi) >= lanes_on)       ? 8'h00 :
                          (s.mr_fmt == FMT_PARALLEL) ? {8{st.rd_data[PBIT]}} :               // [R5] [R6] [R7]
                          (s.mr_fmt == FMT_STAGGER)  ? st.page0[sloc] :                      // [R9]
                                                       st.rd_data;                           // [R3] [R4]
  end

  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    logic take_now;
    take_now  = 1'b0;
    n         = s;
    n.ck_s1   = lnk_ck;
    n.ck_s2   = s.ck_s1;
    n.ck_prev = s.ck_s2;
    n.pin_s1  = {cmd_sel_n, cmd_code, cmd_addr, bank_select_high, bank_select_low};
    n.pin_s2  = s.pin_s1;

    if (mrs_take)
    begin
      n.mr_en   = c_addr[MR_EN_BIT];                                                         // [R12]
      n.mr_page = c_addr[MR_PAGE_LSB +: 2];                                                  // [R12]
      n.mr_fmt  = c_addr[MR_FMT_LSB +: 2];                                                   // [R1]
    end

    // one UI per link edge; a burst is four link periods
    if (link_edge)
    begin
      if (s.bstate == TPRF_BURST && s.ui != 3'h7)
      begin
        n.ui = s.ui + 3'h1;
      end
      // the waiting read goes first so bursts keep command order
      else if (s.pend)
      begin
        n.bstate   = TPRF_BURST;                                                             // [R11]
        n.ui       = 3'h0;
        n.cur_word = s.pend_word;
        n.cur_fmt  = s.pend_fmt;
        n.pend     = 1'b0;
      end
      else if (rd_take)
      begin
        take_now   = 1'b1;
        n.bstate   = TPRF_BURST;
        n.ui       = 3'h0;
        n.cur_word = new_word;
        n.cur_fmt  = s.mr_fmt;
      end
      else
      begin
        n.bstate = TPRF_IDLE;
      end
    end
    // one slot is enough at the shortest read spacing; a third read overwrites it
    if (rd_take && !take_now)
    begin
      n.pend      = 1'b1;                                                                    // [R11]
      n.pend_word = new_word;
      n.pend_fmt  = s.mr_fmt;
    end

    n.oe  = n.bstate == TPRF_BURST;
    n.dqs = n.oe && !n.ui[0];                                                                // [R2]
    for (int i = 0; i < LANES; i++)
    begin
      n.dq[i] = n.oe && n.cur_word[i][3'h7 - n.ui];                                          // [R3]
    end

    // apb: read data prepared in setup so the access phase answers at once
    if (setup_ph)
    begin
      n.err   = 1'b0;
      n.rdata = 32'h0000_0000;
      unique case (paddr)
        OFS_LANE_CFG:
        begin
          n.rdata[1:0] = s.lane_cfg;
        end
        OFS_MODE_STAT:
        begin
          n.rdata[STAT_EN_BIT]        = s.mr_en;
          n.rdata[STAT_PAGE_LSB +: 2] = s.mr_page;
          n.rdata[STAT_FMT_LSB +: 2]  = s.mr_fmt;
          n.rdata[STAT_BUSY_BIT]      = s.oe;
          n.rdata[STAT_PEND_BIT]      = s.pend;
          n.rdata[STAT_IGN_BIT]       = s.ign_flag;
        end
        OFS_PAGE0:
        begin
          n.rdata = st.page0;
        end
        default:
        begin
          n.err = 1'b1;
        end
      endcase
    end
    if (access_ph && pwrite && paddr == OFS_LANE_CFG)
    begin
      n.lane_cfg = pwdata[1:0];
    end
    if (access_ph && pwrite && paddr == OFS_MODE_STAT && pwdata[STAT_IGN_BIT])
    begin
      n.ign_flag = 1'b0;
    end
    // set after clear: an ignored write in the clearing cycle is kept
    if (st.wr_ignored)
    begin
      n.ign_flag = 1'b1;                                                                     // [R16]
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s          <= '0;
      s.lane_cfg <= WID_RESET;
    end
    else
    begin
      s <= n;
    end
  end

  assign prdata  = s.rdata;
  assign pready  = 1'b1;
  assign pslverr = access_ph && s.err;
  assign dq_o    = s.dq;
  assign dq_oe   = s.oe;
  assign dqs_o   = s.dqs;
  assign dqs_oe  = s.oe;                                                                     // [R2]

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic       stag_exp;
  logic [1:0] cfg_fmt;
  assign stag_exp = st.page0[c_bank + 2'h1][7];
  assign cfg_fmt  = c_addr[MR_FMT_LSB +: 2];

  property p_mode_set;
    mrs_take |=> s.mr_fmt == $past(cfg_fmt) && s.mr_en == $past(c_addr[MR_EN_BIT]);
  endproperty
  a_mode_set: assert property (p_mode_set) else $error("mode command not applied"); // [R1] [R12]

  property p_strobe_toggle;
    $past(link_edge) && dq_oe && $past(dq_oe) |-> dqs_oe && dqs_o != $past(dqs_o);
  endproperty
  a_strobe_toggle: assert property (p_strobe_toggle) else $error("strobe did not follow data"); // [R2]

  property p_serial_first;
    rd_take && s.bstate == TPRF_IDLE && s.mr_fmt == FMT_SERIAL
      |=> dq_oe && dq_o[0] == $past(st.rd_data[7]);
  endproperty
  a_serial_first: assert property (p_serial_first) else $error("serial burst wrong first bit"); // [R3] [R4]

  property p_serial_same;
    dq_oe && s.cur_fmt == FMT_SERIAL && s.lane_cfg == WID_X16 |-> dq_o == {16{dq_o[0]}};
  endproperty
  a_serial_same: assert property (p_serial_same) else $error("serial lanes differ"); // [R3]

  property p_par_hold;
    dq_oe && $past(dq_oe) && s.cur_fmt == FMT_PARALLEL && s.ui != 3'h0 |-> $stable(dq_o);
  endproperty
  a_par_hold: assert property (p_par_hold) else $error("parallel lanes changed in burst"); // [R5]

  property p_par_x4;
    dq_oe && s.cur_fmt == FMT_PARALLEL && s.lane_cfg == WID_X4 |-> dq_o[15:4] == 12'h000;
  endproperty
  a_par_x4: assert property (p_par_x4) else $error("x4 parallel drives upper lanes"); // [R6]

  property p_par_x16;
    dq_oe && s.cur_fmt == FMT_PARALLEL && s.lane_cfg == WID_X16 |-> dq_o[15:8] == dq_o[7:0];
  endproperty
  a_par_x16: assert property (p_par_x16) else $error("x16 parallel bytes differ"); // [R7]

  property p_stag_lane1;
    rd_take && s.bstate == TPRF_IDLE && s.mr_fmt == FMT_STAGGER |=> dq_o[1] == $past(stag_exp);
  endproperty
  a_stag_lane1: assert property (p_stag_lane1) else $error("staggered rotation wrong"); // [R9]

  property p_stag_nibble;
    dq_oe && s.cur_fmt == FMT_STAGGER && s.lane_cfg == WID_X16
      |-> dq_o[15:12] == dq_o[3:0] && dq_o[11:8] == dq_o[3:0] && dq_o[7:4] == dq_o[3:0];
  endproperty
  a_stag_nibble: assert property (p_stag_nibble) else $error("staggered nibbles differ"); // [R10]

  property p_no_bubble;
    link_edge && s.oe && s.ui == 3'h7 && (s.pend || rd_take) |=> dq_oe && s.ui == 3'h0;
  endproperty
  a_no_bubble: assert property (p_no_bubble) else $error("gap between bursts"); // [R11]

  c_serial:  cover property (rd_take && s.mr_fmt == FMT_SERIAL && s.mr_page != 2'h0);
  c_par:     cover property (rd_take && s.mr_fmt == FMT_PARALLEL);
  c_stag_bb: cover property (link_edge && s.oe && s.ui == 3'h7 && s.pend && s.pend_fmt == FMT_STAGGER);
  c_ignored: cover property (st.wr_ignored);

endmodule
`default_nettype wire

/* File: inc/tprf_pkg.sv */
`default_nettype none
package tprf_pkg;

  // ****************************************************************
  // data bus shape
  // ****************************************************************
  localparam int          LANES         = 16;
  localparam int          PIN_W         = 18;

  // ****************************************************************
  // link command codes on cmd_code
  // ****************************************************************
  localparam logic [1:0]  CMD_NOP       = 2'h0;
  localparam logic [1:0]  CMD_MRS       = 2'h1;
  localparam logic [1:0]  CMD_RD        = 2'h2;
  localparam logic [1:0]  CMD_WR        = 2'h3;

  // ****************************************************************
  // training_mode_control_register fields on cmd_addr
  // ****************************************************************
  localparam int          MR_EN_BIT     = 2;
  localparam int          MR_PAGE_LSB   = 0;
  localparam int          MR_FMT_LSB    = 11;
  localparam logic [1:0]  FMT_SERIAL    = 2'h0;
  localparam logic [1:0]  FMT_PARALLEL  = 2'h1;
  localparam logic [1:0]  FMT_STAGGER   = 2'h2;

  // ****************************************************************
  // lane width codes
  // ****************************************************************
  localparam logic [1:0]  WID_X4        = 2'h0;
  localparam logic [1:0]  WID_X8        = 2'h1;
  localparam logic [1:0]  WID_X16       = 2'h2;
  localparam logic [1:0]  WID_RESET     = WID_X8;

  // ****************************************************************
  // page 0 power-up pattern
  // ****************************************************************
  localparam logic [7:0]  LOC0_DEFAULT  = 8'h55;
  localparam logic [7:0]  LOC1_DEFAULT  = 8'h33;
  localparam logic [7:0]  LOC2_DEFAULT  = 8'h0F;
  localparam logic [7:0]  LOC3_DEFAULT  = 8'h00;

  // ****************************************************************
  // apb register map
  // ****************************************************************
  localparam logic [7:0]  OFS_LANE_CFG  = 8'h00;
  localparam logic [7:0]  OFS_MODE_STAT = 8'h04;
  localparam logic [7:0]  OFS_PAGE0     = 8'h08;
  localparam int          STAT_EN_BIT   = 0;
  localparam int          STAT_PAGE_LSB = 1;
  localparam int          STAT_FMT_LSB  = 3;
  localparam int          STAT_BUSY_BIT = 5;
  localparam int          STAT_PEND_BIT = 6;
  localparam int          STAT_IGN_BIT  = 7;

  typedef enum logic {TPRF_IDLE, TPRF_BURST} tprf_burst_t;

endpackage
`default_nettype wire

/* File: inc/tprf_store_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface tprf_store_if;
  logic                 wr_en;
  logic [1:0]           wr_page;
  logic [1:0]           wr_loc;
  logic [7:0]           wr_data;
  logic                 wr_ignored;
  logic [1:0]           rd_page;
  logic [1:0]           rd_loc;
  logic [7:0]           rd_data;
  logic [3:0][7:0]      page0;
  logic [2:0][3:0][7:0] ro_data;

  modport store (input wr_en, wr_page, wr_loc, wr_data, rd_page, rd_loc, ro_data,
                 output wr_ignored, rd_data, page0);
  modport user  (output wr_en, wr_page, wr_loc, wr_data, rd_page, rd_loc, ro_data,
                 input wr_ignored, rd_data, page0);
endinterface
`default_nettype wire

/* File: logic/tprf_store.sv */
`timescale 1ns/1ps
`default_nettype none
module tprf_store
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // store access
  tprf_store_if.store      st
);
  import tprf_pkg::*;

  typedef struct packed {
    logic [3:0][7:0] p0;
  } tprf_store_t;

  tprf_store_t s;
  tprf_store_t n;
  logic [1:0]  ro_idx;

  assign ro_idx        = st.rd_page - 2'h1;
  assign st.page0      = s.p0;
  // pages 1 to 3 are fed from outside and never stored here
  assign st.rd_data    = (st.rd_page == 2'h0) ? s.p0[st.rd_loc] : st.ro_data[ro_idx][st.rd_loc];
  assign st.wr_ignored = st.wr_en && (st.wr_page != 2'h0);                                  // [R16]

  always_comb
  begin
    n = s;
    if (st.wr_en && st.wr_page == 2'h0)                                                     // [R13] [R15]
    begin
      n.p0[st.wr_loc] = st.wr_data;                                                         // [R18] [R19]
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '{p0: {LOC3_DEFAULT, LOC2_DEFAULT, LOC1_DEFAULT, LOC0_DEFAULT}};                 // [R14] [R17]
    end
    else
    begin
      s <= n;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ro_write;
    st.wr_en && st.wr_page != 2'h0 |=> $stable(st.page0);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("write to read-only page changed page 0"); // [R16]

  property p_p0_hold;
    !(st.wr_en && st.wr_page == 2'h0) |=> $stable(st.page0);
  endproperty
  a_p0_hold: assert property (p_p0_hold) else $error("page 0 changed without a write"); // [R14] [R15]

  property p_write_lands;
    st.wr_en && st.wr_page == 2'h0 |=> st.page0[$past(st.wr_loc)] == $past(st.wr_data);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("page 0 write did not land"); // [R19]

endmodule
`default_nettype wire

/* File: sim/tprf_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tprf_ctrl_model
(
  // link pins
  output logic                        lnk_ck,
  output logic                        cmd_sel_n,
  output logic [1:0]                  cmd_code,
  output logic [12:0]                 cmd_addr,
  output logic                        bank_select_high,
  output logic                        bank_select_low,
  // data return
  input  wire logic [tprf_pkg::LANES-1:0] dq_o,
  input  wire logic                   dq_oe,
  input  wire logic                   dqs_o,
  input  wire logic                   dqs_oe
);
  import tprf_pkg::*;

  logic [18:0] seen [$];
  logic        watch = 1'b0;

  initial
  begin
    lnk_ck = 1'b0;
    cmd_sel_n = 1'b1;
    cmd_code = CMD_NOP;
    cmd_addr = 13'h0;
    {bank_select_high, bank_select_low} = 2'h0;
  end

  // ****************************************************************
  // one command per link period, pins move on the falling edge
  // ****************************************************************
  task automatic issue(input logic [1:0] code, input logic [12:0] addr, input logic [1:0] loc);
    cmd_sel_n <= 1'b0;
    cmd_code <= code;
    cmd_addr <= addr;
    {bank_select_high, bank_select_low} <= loc;
    #400 lnk_ck <= 1'b1;
    #400 lnk_ck <= 1'b0;
  endtask

  task automatic idle(input int n);
    // released address and bank lines show the inverse and the code goes to NOP, so a stale value never looks valid
    if (!cmd_sel_n)
    begin
      cmd_sel_n <= 1'b1;
      cmd_code <= CMD_NOP;
      cmd_addr <= ~cmd_addr;
      {bank_select_high, bank_select_low} <= ~{bank_select_high, bank_select_low};
    end
    repeat (n)
    begin
      #400 lnk_ck <= 1'b1;
      #400 lnk_ck <= 1'b0;
    end
  endtask

  // capture mid-UI, clear of the device's synchroniser delay
  always @(lnk_ck)
    if (watch)
      fork
        #600 seen.push_back({dq_oe, dqs_oe, dqs_o, dq_o});
      join_none
endmodule
`default_nettype wire

/* File: sim/tprf_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    comparisons++; \
    if ((got) !== (ex)) \
    begin \
      mismatches++; \
      $display("ERROR %s expected %h seen %h", nm, ex, got); \
    end \
  end
module tprf_top_tb;
  import tprf_pkg::*;

  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              lnk_ck;
  logic              cmd_sel_n;
  logic [1:0]        cmd_code;
  logic [12:0]       cmd_addr;
  logic              bsh;
  logic              bsl;
  logic [95:0]       ro = 96'h5C4B3A29_1807F6E5_D4C3B2A1;
  logic [LANES-1:0]  dq_o;
  logic              dq_oe;
  logic              dqs_o;
  logic              dqs_oe;
  logic [7:0]        p0 [4] = '{8'h55, 8'h33, 8'h0F, 8'h00};
  logic [31:0]       r;
  logic              e;
  int                mismatches = 0;
  int                comparisons = 0;
  int                cycles = 0;

  always #50 pclk = ~pclk;

  tprf_top i_tprf_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk_ck(lnk_ck),
    .cmd_sel_n(cmd_sel_n), .cmd_code(cmd_code), .cmd_addr(cmd_addr), .bank_select_high(bsh),
    .bank_select_low(bsl), .ro_page_data(ro), .dq_o(dq_o), .dq_oe(dq_oe), .dqs_o(dqs_o), .dqs_oe(dqs_oe));

  tprf_ctrl_model i_tprf_ctrl_model (.lnk_ck(lnk_ck), .cmd_sel_n(cmd_sel_n), .cmd_code(cmd_code),
    .cmd_addr(cmd_addr), .bank_select_high(bsh), .bank_select_low(bsl), .dq_o(dq_o), .dq_oe(dq_oe),
    .dqs_o(dqs_o), .dqs_oe(dqs_oe));

  // ****************************************************************
  // apb master and closing
  // ****************************************************************
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready is judged at rising edges only; a hang ends at the bench timeout
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic reg_chk(input string nm, input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] rd;
    logic        err;
    apb(a, 1'b0, 32'h0, rd, err);
    `CHK(nm, ex, rd)
  endtask

  task automatic give_verdict();
    if (mismatches == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      mismatches++;
      give_verdict();
    end
  end

  // ****************************************************************
  // expected lanes of one UI
  // ****************************************************************
  function automatic logic [15:0] exp_dq(input logic [1:0] fmt, pg, wid, loc, input int u);
    logic [15:0] v;
    logic [7:0]  b;
    int          w;
    w = (wid == WID_X4) ? 4 : (wid == WID_X8) ? 8 : 16;
    b = (pg == 2'h0) ? p0[loc] : ro[32*(pg-1) + 8*loc +: 8];
    for (int i = 0; i < 16; i++)
    begin
      if (fmt == FMT_PARALLEL)
        v[i] = b[7 - i % 8];
      else if (fmt == FMT_STAGGER)
        v[i] = p0[(loc + i % 4) % 4][7 - u];
      else
        v[i] = b[7 - u];
      v[i] = v[i] & (i < w);
    end
    return v;
  endfunction

  // ****************************************************************
  // mode command, n reads back to back, then every UI judged
  // ****************************************************************
  task automatic burst(input logic en, input logic [1:0] fmt, pg, wid, input logic [7:0] locs, input int n);
    logic [12:0] mr;
    logic [18:0] ex;
    int          j;
    apb(OFS_LANE_CFG, 1'b1, {30'h0, wid}, r, e);
    mr = 13'h0;
    mr[12:11] = fmt;
    mr[2] = en;
    mr[1:0] = pg;
    #130;
    i_tprf_ctrl_model.issue(CMD_MRS, mr, 2'h0);
    i_tprf_ctrl_model.idle(1);
    i_tprf_ctrl_model.seen.delete();
    i_tprf_ctrl_model.watch = 1'b1;
    for (int k = 0; k < n; k++)
    begin
      i_tprf_ctrl_model.issue(CMD_RD, 13'h0, locs[2*k +: 2]);
      // a pair of reads goes out two link periods apart, so the second waits in the slot
      i_tprf_ctrl_model.idle((n == 2 && k == 0) ? 1 : 3);
    end
    i_tprf_ctrl_model.idle(4);
    #700;
    i_tprf_ctrl_model.watch = 1'b0;
    j = 0;
    while (j < i_tprf_ctrl_model.seen.size() && i_tprf_ctrl_model.seen[j][18] !== 1'b1)
      j++;
    for (int k = 0; k < (en ? n : 0); k++)
      for (int u = 0; u < 8; u++)
      begin
        ex = {2'b11, ~u[0], exp_dq(fmt, pg, wid, locs[2*k +: 2], u)};
        `CHK("burst ui", ex, i_tprf_ctrl_model.seen[j])
        j++;
      end
    ex = (j < i_tprf_ctrl_model.seen.size()) ? i_tprf_ctrl_model.seen[j] : 19'h0;
    `CHK("idle after burst", 19'h0, ex)
  endtask

  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    reg_chk("page0 word", OFS_PAGE0, 32'h000F3355);
    apb(8'h10, 1'b1, 32'h0, r, e);
    `CHK("unmapped error", 1'b1, e)
    apb(OFS_PAGE0, 1'b1, 32'hFFFFFFFF, r, e);
    reg_chk("page0 after bus write", OFS_PAGE0, 32'h000F3355);
    #130;
    i_tprf_ctrl_model.issue(CMD_MRS, 13'h0004, 2'h0);
    i_tprf_ctrl_model.issue(CMD_WR, 13'h00A6, 2'h2);
    i_tprf_ctrl_model.issue(CMD_MRS, 13'h0005, 2'h0);
    i_tprf_ctrl_model.issue(CMD_WR, 13'h005A, 2'h1);
    i_tprf_ctrl_model.idle(1);
    p0[2] = 8'hA6;
    reg_chk("page0 after link writes", OFS_PAGE0, 32'h00A63355);
    apb(OFS_MODE_STAT, 1'b0, 32'h0, r, e);
    `CHK("status", 8'h83, r[7:0])
    apb(OFS_MODE_STAT, 1'b1, 32'h80, r, e);
    apb(OFS_MODE_STAT, 1'b0, 32'h0, r, e);
    `CHK("status cleared", 8'h03, r[7:0])
    for (int p = 0; p < 4; p++)
      burst(1'b1, FMT_SERIAL, p[1:0], WID_X16, {6'h0, p[1:0]}, 1);
    burst(1'b1, FMT_SERIAL, 2'h0, WID_X4, 8'h0E, 2);
    // pages 1 to 3 stay serial and format code 11 is never sent
    for (int w = 0; w < 3; w++)
      burst(1'b1, FMT_PARALLEL, 2'h0, w[1:0], 8'h02, 1);
    for (int w = 0; w < 3; w++)
      burst(1'b1, FMT_STAGGER, 2'h0, w[1:0], 8'hE4, 4);
    burst(1'b0, FMT_SERIAL, 2'h0, WID_X8, 8'h00, 1);
    give_verdict();
  end
endmodule
`default_nettype wire
